// ==== hdl/qogc_defs.vh ====
// constants for the offset, gain and coarse mixer register bank
`ifndef QOGC_DEFS_VH
`define QOGC_DEFS_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define QOGC_IDX_W          6
`define QOGC_IDX_C_OFFSET   6'h0A
`define QOGC_IDX_D_OFFSET   6'h0B
`define QOGC_IDX_A_GAIN     6'h0C
`define QOGC_IDX_B_GAIN_MIX 6'h0D
`define QOGC_IDX_C_GAIN     6'h0E
`define QOGC_IDX_AS_CTRL    6'h1E
`define QOGC_IDX_ACT_OFS    6'h1F

// ****************************************************************
// reset values
// ****************************************************************
`define QOGC_RST_OFFSET     16'h0000
`define QOGC_RST_GAIN       16'h0400
`define QOGC_RST_AS_EN      1'h1
`define QOGC_UNITY_GAIN     11'h400

// ****************************************************************
// field positions
// ****************************************************************
`define QOGC_REG_W          16
`define QOGC_OFS_W          13
`define QOGC_OFS_MSB        12
`define QOGC_GAIN_W         11
`define QOGC_GAIN_MSB       10
`define QOGC_GAIN_FRAC      10
`define QOGC_CMIX_F8        15
`define QOGC_CMIX_F4        14
`define QOGC_CMIX_F2        13
`define QOGC_CMIX_NF4       12
`define QOGC_AS_EN_BIT      0
`define QOGC_ACT_D_LSB      16

// ****************************************************************
// bus responses
// ****************************************************************
`define QOGC_RESP_OKAY      2'h0
`define QOGC_RESP_SLVERR    2'h2

`endif

// ==== hdl/qogc_corr.v ====
// one channel of gain and offset correction with saturation
`timescale 1ns/100ps
`include "qogc_defs.vh"

module qogc_corr #(
  parameter SMP_W = 16
) (
  // clock and reset
  input  wire                        i_clk,
  input  wire                        i_rst,
  // sample and correction values
  input  wire [SMP_W-1:0]            i_smp,
  input  wire [`QOGC_GAIN_MSB:0]     i_gain,
  input  wire [`QOGC_OFS_MSB:0]      i_offset,
  // corrected sample
  output reg  [SMP_W-1:0]            o_smp
);

  wire signed [SMP_W+11:0] prod;
  wire signed [SMP_W+1:0]  scaled;
  wire signed [SMP_W+2:0]  sum;
  wire                     ovf;
  wire [SMP_W-1:0]         sat;

  // gain is unsigned 1.10 fixed point, so a zero bit is prefixed
  assign prod   = $signed(i_smp) * $signed({1'b0, i_gain});
  assign scaled = prod[SMP_W+11:`QOGC_GAIN_FRAC];
  // offset counted in converter lsbs, added after the gain
  assign sum    = {scaled[SMP_W+1], scaled} + {{(SMP_W-10){i_offset[`QOGC_OFS_MSB]}}, i_offset};
  // clip instead of wrapping; a wrap would flip the sign of a full-scale tone
  assign ovf    = ~((&sum[SMP_W+2:SMP_W-1]) | ~(|sum[SMP_W+2:SMP_W-1]));
  assign sat    = sum[SMP_W+2] ? {1'b1, {(SMP_W-1){1'b0}}} : {1'b0, {(SMP_W-1){1'b1}}};

  // registered result
  always @(posedge i_clk)
  begin
    if (i_rst)
      o_smp <= {SMP_W{1'b0}};
    else
      o_smp <= ovf ? sat : sum[SMP_W-1:0];
  end

endmodule // qogc_corr

// ==== hdl/qogc_regs.v ====
// offset, gain and coarse mixer registers with an AXI4-Lite slave and datapath
`timescale 1ns/100ps
`include "qogc_defs.vh"

// Overview of operation
// - channel C and D offsets are 13-bit fields 12:0, lsb units, reset zero
// - channel D offset sits in bits 12:0 of its own register, lsb units
// - with auto-sync enabled, writing channel C offset fires an auto-sync
// - auto-sync loads C and D offsets into correction in one cycle
// - writing channel D offset alone leaves the active correction untouched
// - gains A, B, C are unsigned 11-bit fields 10:0, reset to unity
// - gain binary point between bits 9 and 10: one integer, ten fraction bits
// - coarse mixer is 4-bit field 15:12 of channel B gain register, reset zero
// - bit 15 rate/8, bit 14 rate/4, bit 13 rate/2, bit 12 minus rate/4
// - several mixer bits cascade, reaching any plus or minus n/8 of rate
// - reserved upper bits reset to zero; software keeps them zero
module qogc_regs #(
  parameter ADDR_W = 8,
  parameter SMP_W  = 16
) (
  // clock and reset
  input  wire                I_MCLK,
  input  wire                I_RST,
  // axi4-lite write address
  input  wire [ADDR_W-1:0]   S_AXI_AWADDR,
  input  wire [2:0]          S_AXI_AWPROT,
  input  wire                S_AXI_AWVALID,
  output wire                S_AXI_AWREADY,
  // axi4-lite write data
  input  wire [31:0]         S_AXI_WDATA,
  input  wire [3:0]          S_AXI_WSTRB,
  input  wire                S_AXI_WVALID,
  output wire                S_AXI_WREADY,
  // axi4-lite write response
  output wire [1:0]          S_AXI_BRESP,
  output wire                S_AXI_BVALID,
  input  wire                S_AXI_BREADY,
  // axi4-lite read address
  input  wire [ADDR_W-1:0]   S_AXI_ARADDR,
  input  wire [2:0]          S_AXI_ARPROT,
  input  wire                S_AXI_ARVALID,
  output wire                S_AXI_ARREADY,
  // axi4-lite read data
  output wire [31:0]         S_AXI_RDATA,
  output wire [1:0]          S_AXI_RRESP,
  output wire                S_AXI_RVALID,
  input  wire                S_AXI_RREADY,
  // input samples
  input  wire                I_SMP_VALID,
  input  wire [SMP_W-1:0]    I_SMP_A,
  input  wire [SMP_W-1:0]    I_SMP_B,
  input  wire [SMP_W-1:0]    I_SMP_C,
  input  wire [SMP_W-1:0]    I_SMP_D,
  // corrected samples
  output wire                O_SMP_VALID,
  output wire [SMP_W-1:0]    O_SMP_A,
  output wire [SMP_W-1:0]    O_SMP_B,
  output wire [SMP_W-1:0]    O_SMP_C,
  output wire [SMP_W-1:0]    O_SMP_D,
  // coarse mixer rotation, in eighths of the sample rate
  output wire [2:0]          O_CMIX_STEP,
  output wire [2:0]          O_CMIX_PHASE
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg                      aw_held_reg;
  reg  [ADDR_W-1:0]        aw_addr_reg;
  reg                      w_held_reg;
  reg  [15:0]              w_data_reg;
  reg  [1:0]               w_strb_reg;
  reg                      bvalid_reg;
  reg  [1:0]               bresp_reg;
  reg                      rvalid_reg;
  reg  [1:0]               rresp_reg;
  reg  [31:0]              rdata_reg;

  reg  [15:0]              c_ofs_reg;
  reg  [15:0]              d_ofs_reg;
  reg  [15:0]              a_gain_reg;
  reg  [15:0]              b_gain_reg;
  reg  [15:0]              c_gain_reg;
  reg                      as_en_reg;
  reg  [`QOGC_OFS_MSB:0]   act_c_reg;
  reg  [`QOGC_OFS_MSB:0]   act_d_reg;

  reg                      valid_reg;
  reg  [2:0]               cmix_step_reg;
  reg  [2:0]               cmix_phase_reg;

  wire [`QOGC_IDX_W-1:0]   wr_idx;
  wire [`QOGC_IDX_W-1:0]   rd_idx;
  wire                     do_wr;
  wire                     do_rd;
  wire                     wr_c_ofs;
  wire                     wr_d_ofs;
  wire                     wr_a_gain;
  wire                     wr_b_gain;
  wire                     wr_c_gain;
  wire                     wr_as;
  wire                     wr_hit;
  wire [15:0]              c_ofs_next;
  wire                     autosync;
  reg  [31:0]              rd_word;
  reg                      rd_hit;
  wire [2:0]               cmix_step_next;

  wire [4*SMP_W-1:0]       smp_in;
  wire [4*SMP_W-1:0]       smp_out;
  wire [4*`QOGC_GAIN_W-1:0] gain_bus;
  wire [4*`QOGC_OFS_W-1:0] ofs_bus;

  // ****************************************************************
  // byte-lane merge
  // ****************************************************************
  // only the two low lanes carry register bits; upper lanes are dropped
  function [15:0] merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0]  strb;
    begin
      merge[7:0]  = strb[0] ? new_val[7:0]  : old_val[7:0];
      merge[15:8] = strb[1] ? new_val[15:8] : old_val[15:8];
    end
  endfunction

  // ****************************************************************
  // axi4-lite write channels
  // ****************************************************************
  // address and data are held separately so they may arrive in any order
  assign S_AXI_AWREADY = ~aw_held_reg;
  assign S_AXI_WREADY  = ~w_held_reg;
  assign S_AXI_BVALID  = bvalid_reg;
  assign S_AXI_BRESP   = bresp_reg;
  assign do_wr         = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_idx        = aw_addr_reg[`QOGC_IDX_W+1:2];

  // capture of address and data, then one response per write
  always @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_held_reg  <= 1'b0;
      w_data_reg  <= 16'h0000;
      w_strb_reg  <= 2'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `QOGC_RESP_OKAY;
    end
    else
    begin
      if (S_AXI_AWVALID & ~aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      else if (do_wr)
        aw_held_reg <= 1'b0;
      if (S_AXI_WVALID & ~w_held_reg)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA[15:0];
        w_strb_reg <= S_AXI_WSTRB[1:0];
      end
      else if (do_wr)
        w_held_reg <= 1'b0;
      if (do_wr)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? `QOGC_RESP_OKAY : `QOGC_RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
        bvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // write decode
  // ****************************************************************
  assign wr_c_ofs  = do_wr & (wr_idx == `QOGC_IDX_C_OFFSET);
  assign wr_d_ofs  = do_wr & (wr_idx == `QOGC_IDX_D_OFFSET);
  assign wr_a_gain = do_wr & (wr_idx == `QOGC_IDX_A_GAIN);
  assign wr_b_gain = do_wr & (wr_idx == `QOGC_IDX_B_GAIN_MIX);
  assign wr_c_gain = do_wr & (wr_idx == `QOGC_IDX_C_GAIN);
  assign wr_as     = do_wr & (wr_idx == `QOGC_IDX_AS_CTRL);
  assign wr_hit    = wr_c_ofs | wr_d_ofs | wr_a_gain | wr_b_gain | wr_c_gain | wr_as;
  assign c_ofs_next = merge(c_ofs_reg, w_data_reg, w_strb_reg);

  // a channel C offset write is the sync point for the CD pair
  assign autosync  = wr_c_ofs & as_en_reg;

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // reserved bits of the offset and gain registers are stored as written so factory settings read back
  always @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      c_ofs_reg  <= `QOGC_RST_OFFSET;
      d_ofs_reg  <= `QOGC_RST_OFFSET;
      a_gain_reg <= `QOGC_RST_GAIN;
      b_gain_reg <= `QOGC_RST_GAIN;
      c_gain_reg <= `QOGC_RST_GAIN;
      as_en_reg  <= `QOGC_RST_AS_EN;
    end
    else
    begin
      if (wr_c_ofs)
        c_ofs_reg <= c_ofs_next;
      if (wr_d_ofs)
        d_ofs_reg <= merge(d_ofs_reg, w_data_reg, w_strb_reg);
      if (wr_a_gain)
        a_gain_reg <= merge(a_gain_reg, w_data_reg, w_strb_reg);
      if (wr_b_gain)
        b_gain_reg <= merge(b_gain_reg, w_data_reg, w_strb_reg);
      if (wr_c_gain)
        c_gain_reg <= merge(c_gain_reg, w_data_reg, w_strb_reg);
      if (wr_as & w_strb_reg[0])
        as_en_reg <= w_data_reg[`QOGC_AS_EN_BIT];
    end
  end

  // ****************************************************************
  // active cd offsets
  // ****************************************************************
  // both halves load together so the pair never shows a half update;
  // a channel D write alone only changes the shadow
  always @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      act_c_reg <= {`QOGC_OFS_W{1'b0}};
      act_d_reg <= {`QOGC_OFS_W{1'b0}};
    end
    else if (autosync)
    begin
      act_c_reg <= c_ofs_next[`QOGC_OFS_MSB:0];
      act_d_reg <= d_ofs_reg[`QOGC_OFS_MSB:0];
    end
  end

  // ****************************************************************
  // axi4-lite read channels
  // ****************************************************************
  assign S_AXI_ARREADY = ~rvalid_reg;
  assign S_AXI_RVALID  = rvalid_reg;
  assign S_AXI_RRESP   = rresp_reg;
  assign S_AXI_RDATA   = rdata_reg;
  assign do_rd         = S_AXI_ARVALID & ~rvalid_reg;
  assign rd_idx        = S_AXI_ARADDR[`QOGC_IDX_W+1:2];

  // read mux; bits above the register width read as zero
  always @*
  begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (rd_idx)
      `QOGC_IDX_C_OFFSET:   rd_word[15:0] = c_ofs_reg;
      `QOGC_IDX_D_OFFSET:   rd_word[15:0] = d_ofs_reg;
      `QOGC_IDX_A_GAIN:     rd_word[15:0] = a_gain_reg;
      `QOGC_IDX_B_GAIN_MIX: rd_word[15:0] = b_gain_reg;
      `QOGC_IDX_C_GAIN:     rd_word[15:0] = c_gain_reg;
      `QOGC_IDX_AS_CTRL:    rd_word[`QOGC_AS_EN_BIT] = as_en_reg;
      `QOGC_IDX_ACT_OFS:
      begin
        rd_word[`QOGC_OFS_MSB:0] = act_c_reg;
        rd_word[`QOGC_ACT_D_LSB+`QOGC_OFS_MSB:`QOGC_ACT_D_LSB] = act_d_reg;
      end
      default:              rd_hit = 1'b0;
    endcase
  end

  // one read at a time; data registered a cycle after the address
  always @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `QOGC_RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end
    else if (do_rd)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_hit ? `QOGC_RESP_OKAY : `QOGC_RESP_SLVERR;
      rdata_reg  <= rd_word;
    end
    else if (S_AXI_RREADY)
      rvalid_reg <= 1'b0;
  end

  // ****************************************************************
  // coarse mixer
  // ****************************************************************
  // each bit adds its own rotation; the sum wraps modulo eight eighths,
  // so minus rate/4 is plus six eighths
  assign cmix_step_next = {b_gain_reg[`QOGC_CMIX_F2], b_gain_reg[`QOGC_CMIX_F4], b_gain_reg[`QOGC_CMIX_F8]}
                        + (b_gain_reg[`QOGC_CMIX_NF4] ? 3'h6 : 3'h0);

  // phase advances once per valid sample, aligned with the corrected output
  always @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      cmix_step_reg  <= 3'h0;
      cmix_phase_reg <= 3'h0;
    end
    else
    begin
      cmix_step_reg <= cmix_step_next;
      if (I_SMP_VALID)
        cmix_phase_reg <= cmix_phase_reg + cmix_step_next;
    end
  end

  assign O_CMIX_STEP  = cmix_step_reg;
  assign O_CMIX_PHASE = cmix_phase_reg;

  // ****************************************************************
  // correction datapath
  // ****************************************************************
  // channel D gain and AB offsets are not held here: unity and zero
  assign smp_in   = {I_SMP_D, I_SMP_C, I_SMP_B, I_SMP_A};
  assign gain_bus = {`QOGC_UNITY_GAIN, c_gain_reg[`QOGC_GAIN_MSB:0],
                     b_gain_reg[`QOGC_GAIN_MSB:0], a_gain_reg[`QOGC_GAIN_MSB:0]};
  assign ofs_bus  = {act_d_reg, act_c_reg, {`QOGC_OFS_W{1'b0}}, {`QOGC_OFS_W{1'b0}}};

  // one correction slice per channel
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_chan
      qogc_corr #(
        .SMP_W    (SMP_W)
      ) u_corr (
        .i_clk    (I_MCLK),
        .i_rst    (I_RST),
        .i_smp    (smp_in[ch*SMP_W +: SMP_W]),
        .i_gain   (gain_bus[ch*`QOGC_GAIN_W +: `QOGC_GAIN_W]),
        .i_offset (ofs_bus[ch*`QOGC_OFS_W +: `QOGC_OFS_W]),
        .o_smp    (smp_out[ch*SMP_W +: SMP_W])
      );
    end
  endgenerate

  // valid follows the one-cycle datapath latency
  always @(posedge I_MCLK)
  begin
    if (I_RST)
      valid_reg <= 1'b0;
    else
      valid_reg <= I_SMP_VALID;
  end

  assign O_SMP_VALID = valid_reg;
  assign O_SMP_A     = smp_out[0*SMP_W +: SMP_W];
  assign O_SMP_B     = smp_out[1*SMP_W +: SMP_W];
  assign O_SMP_C     = smp_out[2*SMP_W +: SMP_W];
  assign O_SMP_D     = smp_out[3*SMP_W +: SMP_W];

endmodule // qogc_regs

// ==== testbench/qogc_regs_monitor.sv ====
// port-level checks of bus handshakes, sample timing and mixer phase
`timescale 1ns/100ps
`include "qogc_defs.vh"

module qogc_regs_monitor #(
  parameter ADDR_W = 8
) (
  // clock and reset
  input wire              I_MCLK,
  input wire              I_RST,
  // bus channels
  input wire              S_AXI_AWVALID,
  input wire              S_AXI_AWREADY,
  input wire              S_AXI_WVALID,
  input wire              S_AXI_WREADY,
  input wire              S_AXI_BVALID,
  input wire              S_AXI_BREADY,
  input wire [ADDR_W-1:0] S_AXI_ARADDR,
  input wire              S_AXI_ARVALID,
  input wire              S_AXI_ARREADY,
  input wire [31:0]       S_AXI_RDATA,
  input wire [1:0]        S_AXI_RRESP,
  input wire              S_AXI_RVALID,
  input wire              S_AXI_RREADY,
  // samples and mixer
  input wire              I_SMP_VALID,
  input wire              O_SMP_VALID,
  input wire [2:0]        O_CMIX_STEP,
  input wire [2:0]        O_CMIX_PHASE
);
  // ****************************************************************
  // read index tracking
  // ****************************************************************
  reg  [5:0] ar_idx_reg;
  wire       idx_mapped;

  // keep the accepted read index so the answer can be judged later
  always @(posedge I_MCLK)
  begin
    if (S_AXI_ARVALID && S_AXI_ARREADY)
      ar_idx_reg <= S_AXI_ARADDR[7:2];
  end

  // the bank is five words plus the two control words above it
  assign idx_mapped = (ar_idx_reg >= `QOGC_IDX_C_OFFSET && ar_idx_reg <= `QOGC_IDX_C_GAIN) ||
                      ar_idx_reg == `QOGC_IDX_AS_CTRL || ar_idx_reg == `QOGC_IDX_ACT_OFS;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_reset_idle: assert property ($past(I_RST) |-> S_AXI_AWREADY && S_AXI_WREADY && !S_AXI_BVALID && !S_AXI_RVALID)
    else $error("bus not idle after reset");
  a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped early");
  a_bvalid_drop: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response repeated");
  a_rvalid_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
    else $error("read answer changed while stalled");
  a_write_latency: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && !S_AXI_BVALID
    |=> !S_AXI_AWREADY && !S_AXI_WREADY ##1 S_AXI_BVALID)
    else $error("write response late");
  a_read_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer late");
  a_unmapped_read: assert property ($rose(S_AXI_RVALID) && !idx_mapped
    |-> S_AXI_RRESP == `QOGC_RESP_SLVERR && S_AXI_RDATA == 32'h00000000)
    else $error("unmapped read not refused");
  a_mapped_read: assert property ($rose(S_AXI_RVALID) && idx_mapped |-> S_AXI_RRESP == `QOGC_RESP_OKAY &&
    (ar_idx_reg == `QOGC_IDX_ACT_OFS || S_AXI_RDATA[31:16] == 16'h0))
    else $error("mapped read wrong");
  a_smp_valid: assert property (!$past(I_RST) |-> O_SMP_VALID == $past(I_SMP_VALID))
    else $error("sample valid not one cycle late");
  a_phase_hold: assert property (!$past(I_RST) && !$past(I_SMP_VALID) |-> $stable(O_CMIX_PHASE))
    else $error("phase moved without sample");
  a_phase_accum: assert property (!$past(I_RST) && $past(I_SMP_VALID) && $stable(O_CMIX_STEP)
    |-> O_CMIX_PHASE == 3'($past(O_CMIX_PHASE) + $past(O_CMIX_STEP)))
    else $error("phase did not advance by step");
endmodule // qogc_regs_monitor

bind qogc_regs qogc_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (
  .I_MCLK(I_MCLK), .I_RST(I_RST), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .I_SMP_VALID(I_SMP_VALID),
  .O_SMP_VALID(O_SMP_VALID), .O_CMIX_STEP(O_CMIX_STEP), .O_CMIX_PHASE(O_CMIX_PHASE)
);

// ==== testbench/qogc_host.sv ====
// axi4-lite host model that programs the register bank
`timescale 1ns/100ps

module qogc_host (
  // clock
  input  wire        i_clk,
  // write channels
  output reg  [7:0]  o_awaddr,
  output reg         o_awvalid,
  input  wire        i_awready,
  output reg  [31:0] o_wdata,
  output reg         o_wvalid,
  input  wire        i_wready,
  input  wire [1:0]  i_bresp,
  input  wire        i_bvalid,
  output reg         o_bready,
  // read channels
  output reg  [7:0]  o_araddr,
  output reg         o_arvalid,
  input  wire        i_arready,
  input  wire [31:0] i_rdata,
  input  wire [1:0]  i_rresp,
  input  wire        i_rvalid,
  output reg         o_rready
);
  int slow = 0; // stall cycles before each answer is accepted

  initial
  begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    {o_awaddr, o_araddr, o_wdata} = 48'h0;
  end

  // address and data offered together; released lines show the inverse, not a stale value
  task automatic write(input [7:0] a, input [15:0] d, output [1:0] r);
    bit ad;
    bit dd;
    ad = 0;
    dd = 0;
    @(posedge i_clk);
    o_awaddr  <= a;
    o_wdata   <= {16'h0000, d};
    o_awvalid <= 1'b1;
    o_wvalid  <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge i_clk);
      if (!ad && i_awready)
      begin
        ad = 1;
        o_awvalid <= 1'b0;
        o_awaddr  <= ~a;
      end
      if (!dd && i_wready)
      begin
        dd = 1;
        o_wvalid <= 1'b0;
        o_wdata  <= ~{16'h0000, d};
      end
    end
    repeat (slow) @(posedge i_clk);
    o_bready <= 1'b1;
    do @(posedge i_clk); while (!i_bvalid);
    r = i_bresp;
    o_bready <= 1'b0;
  endtask

  // one read; ready may come late to exercise the slave's hold
  task automatic read(input [7:0] a, output [31:0] d, output [1:0] r);
    @(posedge i_clk);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    do @(posedge i_clk); while (!i_arready);
    o_arvalid <= 1'b0;
    o_araddr  <= ~a;
    repeat (slow) @(posedge i_clk);
    o_rready <= 1'b1;
    do @(posedge i_clk); while (!i_rvalid);
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
  endtask
endmodule // qogc_host

// ==== testbench/test_qmc_offset_gain_cmix_regs.sv ====
// self-checking bench for the offset, gain and coarse mixer register bank
`timescale 1ns/100ps
`include "qogc_defs.vh"

module test_qmc_offset_gain_cmix_regs;
  localparam [1:0] OK  = `QOGC_RESP_OKAY;
  localparam [1:0] ERR = `QOGC_RESP_SLVERR;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         smp_v = 1'b0;
  reg  [15:0] s_a = 16'h0000, s_b = 16'h0000, s_c = 16'h0000, s_d = 16'h0000;
  wire [7:0]  aw_a, ar_a;
  wire [31:0] w_d, r_d;
  wire [1:0]  b_rsp, r_rsp;
  wire        aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, o_v;
  wire [15:0] o_a, o_b, o_c, o_d;
  wire [2:0]  step, phase;
  int         n_errors = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         e;
  int         ph;
  reg  [31:0] rd_d;
  reg  [1:0]  rsp;

  qogc_regs u_dut (
    .I_MCLK(clk), .I_RST(rst), .S_AXI_AWADDR(aw_a), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(aw_v),
    .S_AXI_AWREADY(aw_r), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_r),
    .S_AXI_BRESP(b_rsp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ar_a), .S_AXI_ARPROT(3'h0),
    .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_r), .S_AXI_RDATA(r_d), .S_AXI_RRESP(r_rsp), .S_AXI_RVALID(r_v),
    .S_AXI_RREADY(r_r), .I_SMP_VALID(smp_v), .I_SMP_A(s_a), .I_SMP_B(s_b), .I_SMP_C(s_c), .I_SMP_D(s_d),
    .O_SMP_VALID(o_v), .O_SMP_A(o_a), .O_SMP_B(o_b), .O_SMP_C(o_c), .O_SMP_D(o_d),
    .O_CMIX_STEP(step), .O_CMIX_PHASE(phase));

  qogc_host u_host (
    .i_clk(clk), .o_awaddr(aw_a), .o_awvalid(aw_v), .i_awready(aw_r), .o_wdata(w_d), .o_wvalid(w_v),
    .i_wready(w_r), .i_bresp(b_rsp), .i_bvalid(b_v), .o_bready(b_r), .o_araddr(ar_a), .o_arvalid(ar_v),
    .i_arready(ar_r), .i_rdata(r_d), .i_rresp(r_rsp), .i_rvalid(r_v), .o_rready(r_r));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string nm, input [31:0] x, input [31:0] g);
    tests_run++;
    if (g !== x)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic wr(input [7:0] a, input [15:0] d, input [1:0] er);
    u_host.write(a, d, rsp);
    chk($sformatf("bresp %h", a), er, rsp);
  endtask

  task automatic rd(input [7:0] a, input [31:0] x, input [1:0] er);
    u_host.read(a, rd_d, rsp);
    chk($sformatf("rresp %h", a), er, rsp);
    chk($sformatf("rdata %h", a), x, rd_d);
  endtask

  // samples are held constant, so three edges cover the one-cycle slice
  task automatic outs(input [15:0] xa, input [15:0] xb, input [15:0] xc, input [15:0] xd);
    repeat (3) @(posedge clk);
    chk("out a", xa, o_a);
    chk("out b", xb, o_b);
    chk("out c", xc, o_c);
    chk("out d", xd, o_d);
  endtask

  task automatic summarize;
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial forever #2 clk = ~clk;

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      n_errors++;
      summarize();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    u_host.slow = 2;
    rd(8'h28, 32'h00000000, OK);
    rd(8'h2C, 32'h00000000, OK);
    rd(8'h30, 32'h00000400, OK);
    rd(8'h34, 32'h00000400, OK);
    rd(8'h38, 32'h00000400, OK);
    rd(8'h78, 32'h00000001, OK);
    rd(8'h40, 32'h00000000, ERR);
    wr(8'h00, 16'h0055, ERR);
    wr(8'h7C, 16'h0055, ERR);
    u_host.slow = 0;
    wr(8'h30, 16'h0200, OK);
    wr(8'h34, 16'h07FF, OK);
    wr(8'h38, 16'h0000, OK);
    {s_a, s_b, s_c, s_d} <= 64'hC000_7000_1234_8000;
    outs(16'hE000, 16'h7FFF, 16'h0000, 16'h8000);
    wr(8'h2C, 16'h0123, OK);
    rd(8'h7C, 32'h00000000, OK);
    outs(16'hE000, 16'h7FFF, 16'h0000, 16'h8000);
    wr(8'h28, 16'h1FFF, OK);
    rd(8'h7C, 32'h01231FFF, OK);
    outs(16'hE000, 16'h7FFF, 16'hFFFF, 16'h8123);
    wr(8'h78, 16'h0000, OK);
    wr(8'h2C, 16'h1000, OK);
    wr(8'h28, 16'h0011, OK);
    rd(8'h7C, 32'h01231FFF, OK);
    rd(8'h28, 32'h00000011, OK);
    rd(8'h2C, 32'h00001000, OK);
    wr(8'h78, 16'h0001, OK);
    wr(8'h28, 16'h0011, OK);
    rd(8'h7C, 32'h10000011, OK);
    outs(16'hE000, 16'h7FFF, 16'h0011, 16'h8000);
    // every mixer code, with the phase advanced by three samples each time
    for (int n = 0; n < 16; n++)
    begin
      wr(8'h34, {n[3:0], 12'h7FF}, OK);
      rd(8'h34, {16'h0000, n[3:0], 12'h7FF}, OK);
      e = (n[3] + 2 * n[2] + 4 * n[1] + 8 - 2 * n[0]) % 8;
      chk("step", e, step);
      ph = phase;
      @(posedge clk);
      smp_v <= 1'b1;
      repeat (3) @(posedge clk);
      smp_v <= 1'b0;
      @(posedge clk);
      chk("phase", (ph + 3 * e) % 8, phase);
    end
    summarize();
  end
endmodule // test_qmc_offset_gain_cmix_regs
